// >>> indicator_consts.svh
/*
 * constants for the indicator serial status and control block:
 * frame characters, command letters and the interrupt bit layout.
 * assumes it is included by name and compiled before any module.
 */
`ifndef INDICATOR_CONSTS_SVH
`define INDICATOR_CONSTS_SVH

`define FRAME_LEN      5'd20
`define CH_CR          8'h0D
`define CH_LF          8'h0A
`define CH_COMMA       8'h2C
`define CH_MINUS       8'h2D
`define CH_ZERO        8'h30
`define CH_HDR0        8'h47
`define CH_HDR1        8'h53
`define ST_OVER        8'h4F
`define ST_STABLE      8'h53
`define ST_UNSTABLE    8'h4D
`define ST_HOLD        8'h48
`define TRK_OFF        8'h41
`define TRK_ON         8'h54
`define DEC_HIGH       8'h48
`define DEC_LOW        8'h4C
`define DEC_HH         8'h4F
`define DEC_LL         8'h55
`define DEC_OK         8'h47
`define DEC_NONE       8'h46
`define NZ_OFF         8'h4E
`define NZ_ON          8'h5A
`define CMD_LEAD       8'h43
`define CMD_HOLD_ON    8'h45
`define CMD_HOLD_OFF   8'h46
`define CMD_ZERO_SET   8'h47
`define CMD_ZERO_CLR   8'h48
`define CMD_HOLD_REL   8'h49
`define CMD_TRIG_ON    8'h4A
`define CMD_TRIG_OFF   8'h4B
`define CMD_FRAME_REQ  8'h52
`define IRQ_ADDR_STAT  2'h0
`define IRQ_ADDR_MASK  2'h1
`define IRQ_ADDR_CTRL  2'h2
`define IRQ_BIT_FRAME  0
`define IRQ_BIT_CMD    1
`define IRQ_BIT_REJ    2
`define IRQ_BIT_BAD    3
`define IRQ_W          4

`endif

// >>> indicator_pkg.sv
/*
 * types for the indicator serial status and control block.
 * assumes indicator_consts.svh is compiled alongside.
 */
package indicator_pkg;
   typedef enum logic [1:0] {
      hold_mode_off,
      hold_mode_a,
      hold_mode_b,
      hold_mode_c
   } hold_mode_t;

   typedef enum logic [1:0] {
      rx_idle,
      rx_letter,
      rx_term
   } rx_state_t;
endpackage : indicator_pkg

// >>> indicator_serial.sv
/*
 * serial status frame generator and two-letter command interpreter
 * for a load indicator. bytes arrive and leave as parallel bytes with
 * valid/ready; the uart itself sits outside. assumes one clock, with
 * inputs synchronous to it, and that the host keeps its command format.
 */
`timescale 1ns/1ps
`include "indicator_consts.svh"

module indicator_serial
   import indicator_pkg::*;
#(
   parameter int DIGITS = 5
) (
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   input  wire logic                    clk_en,
   input  wire logic                    tx_mode,
   input  indicator_pkg::hold_mode_t    hold_mode,
   input  wire logic                    zero_permit,
   input  wire logic                    cal_lock,
   input  wire logic                    decision_trigger_permit,
   input  wire logic                    overflow,
   input  wire logic                    stable,
   input  wire logic                    zero_tracking,
   input  wire logic                    near_zero,
   input  wire logic                    high_high_limit,
   input  wire logic                    upper_limit,
   input  wire logic                    ok_out,
   input  wire logic                    bottom_limit,
   input  wire logic                    low_low_limit,
   input  wire logic                    reading_neg,
   input  wire logic [4*DIGITS-1:0]     reading_bcd,
   input  wire logic [7:0]              rx_data,
   input  wire logic                    rx_valid,
   output logic                         rx_ready,
   output logic [7:0]                   tx_data,
   output logic                         tx_valid,
   input  wire logic                    tx_ready,
   output logic                         hold_active,
   output logic                         zero_set_pulse,
   output logic                         zero_clear_pulse,
   output logic                         decision_trigger_input,
   input  wire logic [1:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [7:0]                   reg_rdata,
   output logic                         irq
);
   import indicator_pkg::*;

   localparam int HDR_LEN = 15;

   rx_state_t                 rx_state_reg;
   logic [7:0]                cmd_letter_reg;
   logic                      req_lead_reg;
   logic [4:0]                tx_idx_reg;
   logic                      req_pend_reg;
   logic [`IRQ_W-1:0]         irq_stat_reg;
   logic [`IRQ_W-1:0]         irq_mask_reg;
   logic                      frame_done;
   logic                      cmd_ok;
   logic                      cmd_rej;
   logic                      cmd_bad;
   logic                      term_seen;
   logic [7:0]                frame_char;
   logic [`IRQ_W-1:0]         irq_events;

   function automatic logic [7:0] status_char(input logic hold,
                                              input logic ovf,
                                              input logic stb);
      if (hold)
         return `ST_HOLD;
      else if (ovf)
         return `ST_OVER;
      else if (stb)
         return `ST_STABLE;
      else
         return `ST_UNSTABLE;
   endfunction : status_char

   function automatic logic [7:0] decision_char(input logic hh,
                                                input logic ll,
                                                input logic hi,
                                                input logic lo,
                                                input logic ok);
      if (hh)
         return `DEC_HH;
      else if (ll)
         return `DEC_LL;
      else if (hi)
         return `DEC_HIGH;
      else if (lo)
         return `DEC_LOW;
      else if (ok)
         return `DEC_OK;
      else
         return `DEC_NONE;
   endfunction : decision_char

   // frame byte selection; digits are packed most significant first
   always_comb begin
      frame_char = `CH_COMMA;
      case (tx_idx_reg)
         5'd0:  frame_char = `CH_HDR0;
         5'd1:  frame_char = `CH_HDR1;
         5'd3:  frame_char = status_char(hold_active, overflow, stable);
         5'd5:  frame_char = zero_tracking ? `TRK_ON : `TRK_OFF;
         5'd7:  frame_char = decision_char(high_high_limit, low_low_limit,
                                           upper_limit, bottom_limit, ok_out);
         5'd9:  frame_char = near_zero ? `NZ_ON : `NZ_OFF;
         5'd11: frame_char = reading_neg ? `CH_MINUS : `CH_ZERO;
         5'd18: frame_char = `CH_CR;
         5'd19: frame_char = `CH_LF;
         default: begin
            if (tx_idx_reg >= 5'd12 && tx_idx_reg < 5'(HDR_LEN - 3 + DIGITS))
               frame_char = `CH_ZERO | {4'h0, reading_bcd[
                  4*(DIGITS-1-(int'(tx_idx_reg)-12)) +: 4]};
            else
               frame_char = `CH_COMMA;
         end
      endcase
   end

   assign frame_done = tx_valid && tx_ready &&
                       tx_idx_reg == `FRAME_LEN - 5'd1;

   // frames stream back to back in mode 1, one per request in mode 0
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         tx_idx_reg <= 5'h00;
         tx_valid   <= 1'b0;
         tx_data    <= 8'h00;
      end else if (clk_en) begin
         if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
            if (tx_idx_reg == `FRAME_LEN - 5'd1)
               tx_idx_reg <= 5'h00;
            else
               tx_idx_reg <= tx_idx_reg + 5'd1;
         end else if (!tx_valid &&
                      (tx_mode || req_pend_reg || tx_idx_reg != 5'h00)) begin
            tx_data  <= frame_char;
            tx_valid <= 1'b1;
         end
      end
   end

   assign term_seen = rx_valid && rx_data == `CH_CR;

   // command parser: lead letter, command letter, then carriage return
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rx_state_reg   <= rx_idle;
         cmd_letter_reg <= 8'h00;
         req_lead_reg   <= 1'b0;
      end else if (clk_en && rx_valid) begin
         case (rx_state_reg)
            rx_idle: begin
               if (rx_data == `CMD_LEAD || rx_data == `CMD_FRAME_REQ)
                  rx_state_reg <= rx_letter;
               req_lead_reg <= rx_data == `CMD_FRAME_REQ;
            end
            // the lead picks the command family; a control lead with the
            // request letter is no command and falls through as malformed
            rx_letter: begin
               if (req_lead_reg)
                  cmd_letter_reg <= `CMD_FRAME_REQ;
               else if (rx_data == `CMD_FRAME_REQ)
                  cmd_letter_reg <= 8'h00;
               else
                  cmd_letter_reg <= rx_data;
               rx_state_reg   <= term_seen ? rx_idle : rx_term;
            end
            rx_term:
               rx_state_reg <= rx_idle;
            default:
               rx_state_reg <= rx_idle;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         rx_ready <= 1'b0;
      else if (clk_en)
         rx_ready <= 1'b1;
   end

   // command execution with gating
   always_comb begin
      cmd_ok  = 1'b0;
      cmd_rej = 1'b0;
      cmd_bad = 1'b0;
      if (clk_en && rx_state_reg == rx_term && rx_valid) begin
         if (!term_seen)
            cmd_bad = 1'b1;
         else begin
            case (cmd_letter_reg)
               `CMD_HOLD_ON, `CMD_HOLD_OFF:
                  cmd_ok = hold_mode != hold_mode_off;
               `CMD_ZERO_SET:
                  cmd_ok = zero_permit && cal_lock;
               `CMD_ZERO_CLR:
                  cmd_ok = zero_permit;
               `CMD_HOLD_REL:
                  cmd_ok = hold_active;
               `CMD_TRIG_ON, `CMD_TRIG_OFF:
                  cmd_ok = decision_trigger_permit;
               `CMD_FRAME_REQ:
                  cmd_ok = 1'b1;
               default:
                  cmd_bad = 1'b1;
            endcase
            cmd_rej = !cmd_ok && !cmd_bad;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         hold_active <= 1'b0;
      end else if (clk_en) begin
         if (hold_mode == hold_mode_off)
            hold_active <= 1'b0;
         else if (cmd_ok && cmd_letter_reg == `CMD_HOLD_ON)
            hold_active <= 1'b1;
         else if (cmd_ok && (cmd_letter_reg == `CMD_HOLD_OFF ||
                             cmd_letter_reg == `CMD_HOLD_REL))
            hold_active <= 1'b0;
      end
   end

   // zero pulses last one clk_en cycle; the offset store lives downstream
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         zero_set_pulse   <= 1'b0;
         zero_clear_pulse <= 1'b0;
      end else if (clk_en) begin
         zero_set_pulse   <= cmd_ok && cmd_letter_reg == `CMD_ZERO_SET;
         zero_clear_pulse <= cmd_ok && cmd_letter_reg == `CMD_ZERO_CLR;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         decision_trigger_input <= 1'b0;
      else if (clk_en && cmd_ok) begin
         if (cmd_letter_reg == `CMD_TRIG_ON)
            decision_trigger_input <= 1'b1;
         else if (cmd_letter_reg == `CMD_TRIG_OFF)
            decision_trigger_input <= 1'b0;
      end
   end

   // a request made mid-frame is served once that frame ends
   always_ff @(posedge ref_clk) begin
      if (!nrst)
         req_pend_reg <= 1'b0;
      else if (clk_en) begin
         if (cmd_ok && cmd_letter_reg == `CMD_FRAME_REQ)
            req_pend_reg <= 1'b1;
         else if (tx_valid && tx_idx_reg == 5'h00)
            req_pend_reg <= 1'b0;
      end
   end

   assign irq_events = {cmd_bad, cmd_rej, cmd_ok, frame_done};

   // sticky status; a new event beats a same-cycle write-one clear
   always_ff @(posedge ref_clk) begin
      if (!nrst)
         irq_stat_reg <= '0;
      else if (clk_en)
         irq_stat_reg <= (irq_stat_reg &
                          ~((reg_wr && reg_addr == `IRQ_ADDR_STAT) ?
                            reg_wdata[`IRQ_W-1:0] : '0)) | irq_events;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         irq_mask_reg <= '0;
      else if (clk_en && reg_wr && reg_addr == `IRQ_ADDR_MASK)
         irq_mask_reg <= reg_wdata[`IRQ_W-1:0];
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
         irq       <= 1'b0;
      end else if (clk_en) begin
         irq <= |(irq_stat_reg & irq_mask_reg);
         if (reg_rd) begin
            case (reg_addr)
               `IRQ_ADDR_STAT: reg_rdata <= {4'h0, irq_stat_reg};
               `IRQ_ADDR_MASK: reg_rdata <= {4'h0, irq_mask_reg};
               `IRQ_ADDR_CTRL: reg_rdata <= {5'h00, decision_trigger_input,
                                             hold_active, tx_mode};
               default:        reg_rdata <= 8'h00;
            endcase
         end else
            reg_rdata <= 8'h00;
      end
   end

   sequence s_release_cmd;
      cmd_ok && cmd_letter_reg == `CMD_HOLD_REL;
   endsequence

   sequence s_hold_drops;
      hold_active ##1 !hold_active;
   endsequence

   // pulses freeze with clk_en low, so only a freshly loaded one is judged
   a_hold_gate: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      hold_mode == hold_mode_off && clk_en |=> !hold_active)
      else $error("hold active while hold mode off");
   a_zero_gate: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      zero_set_pulse && $past(clk_en) |->
         $past(zero_permit) && $past(cal_lock))
      else $error("zero set without permit and lock");
   a_zero_clr: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      zero_clear_pulse && $past(clk_en) |-> $past(zero_permit))
      else $error("zero clear without permit");
   a_trig_gate: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $changed(decision_trigger_input) |-> $past(decision_trigger_permit))
      else $error("trigger moved without permit");
   a_frame_end: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      tx_valid && tx_idx_reg == 5'd19 |-> tx_data == `CH_LF)
      else $error("frame does not end in line feed");
   a_status_hold: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $rose(tx_valid) && tx_idx_reg == 5'd3 && $past(hold_active)
      |-> tx_data == `ST_HOLD)
      else $error("hold not reported first");
   a_mode0_quiet: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !tx_mode && !req_pend_reg && tx_idx_reg == 5'h00 && !tx_valid
      && clk_en |=> !tx_valid)
      else $error("frame started in mode 0 without request");
   a_release: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      s_release_cmd |-> s_hold_drops)
      else $error("hold release misbehaved");
endmodule : indicator_serial

// >>> host_link_model.sv
/*
 host end of the serial byte link: sends command bytes and collects
 frame bytes, holding tx_ready back for a set number of cycles.
 assumes the byte handshake of the design and one shared clock.
*/
`timescale 1ns/1ps
module host_link_model (
   input  wire logic       ref_clk,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic [3:0] stall
);
   logic [7:0] got[$];
   logic [3:0] wait_cnt;

   initial begin
      rx_data  = 8'hFF;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
      wait_cnt = 4'h0;
   end

   // sends the characters of s as given, no cr added, each held until rx_ready
   task automatic send(input string s);
      @(posedge ref_clk);
      foreach (s[i]) begin
         rx_data  <= s[i];
         rx_valid <= 1'b1;
         @(posedge ref_clk);
         while (!rx_ready) @(posedge ref_clk);
      end
      rx_valid <= 1'b0;
      // released line shows the inverse so a stale byte cannot match
      rx_data  <= ~rx_data;
   endtask : send

   always @(posedge ref_clk) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
         tx_ready <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (tx_valid && wait_cnt >= stall) begin
         tx_ready <= 1'b1;
      end else if (tx_valid) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : host_link_model

// >>> indicator_serial_status_and_control_test.sv
/*
 testbench for the indicator serial block: frames, commands, registers.
 assumes host_link_model and the design are compiled before it.
*/
`timescale 1ns/1ps
module indicator_serial_status_and_control_test;
   import indicator_pkg::*;
   logic        ref_clk, nrst, clk_en, tx_mode, zero_permit, cal_lock;
   logic        decision_trigger_permit, overflow, stable, zero_tracking;
   logic        near_zero, high_high_limit, upper_limit, ok_out;
   logic        bottom_limit, low_low_limit, reading_neg, rx_ready;
   logic        rx_valid, tx_valid, tx_ready, hold_active, irq, reg_wr;
   logic        zero_set_pulse, zero_clear_pulse, decision_trigger_input;
   logic        reg_rd;
   logic [19:0] reading_bcd;
   logic [7:0]  rx_data, tx_data, reg_wdata, reg_rdata;
   logic [1:0]  reg_addr;
   logic [3:0]  stall;
   hold_mode_t  hold_mode;
   int          fails, samples_checked, zset_n, zclr_n;
   // inputs {ovf,stb,hh,hi,ok,lo,ll,neg}, status char, decision char
   logic [23:0] tbl [8] = '{24'hE94F4F, 24'h465355, 24'h104D48,
      24'h45534C, 24'h485347, 24'h804F46, 24'h4A5355, 24'h70534F};

   indicator_serial #(.DIGITS(5)) indicator_serial_i (.ref_clk, .nrst,
      .clk_en, .tx_mode, .hold_mode, .zero_permit, .cal_lock,
      .decision_trigger_permit, .overflow, .stable, .zero_tracking,
      .near_zero, .high_high_limit, .upper_limit, .ok_out, .bottom_limit,
      .low_low_limit, .reading_neg, .reading_bcd, .rx_data, .rx_valid,
      .rx_ready, .tx_data, .tx_valid, .tx_ready, .hold_active,
      .zero_set_pulse, .zero_clear_pulse, .decision_trigger_input,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

   host_link_model host_link_model_i (.ref_clk, .rx_data, .rx_valid,
      .rx_ready, .tx_data, .tx_valid, .tx_ready, .stall);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (zero_set_pulse === 1'b1) zset_n++;
      if (zero_clear_pulse === 1'b1) zclr_n++;
   end

   task automatic final_report;
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [1:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      check(reg_rdata, e);
   endtask : rchk

   task automatic set_in(input logic [7:0] v);
      {overflow, stable, high_high_limit, upper_limit, ok_out,
       bottom_limit, low_low_limit, reading_neg} <= v;
   endtask : set_in

   task automatic wait_lf;
      int n;
      n = 0;
      while (!(host_link_model_i.got.size() > 0 &&
               host_link_model_i.got[$] === 8'h0A) && n < 900) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 900) fails++;
   endtask : wait_lf

   // skips a frame that may have started on old inputs when streaming
   task automatic frame(input logic req, input logic [7:0] st, dc);
      logic [7:0] e[12];
      int         n;
      if (!req) begin
         host_link_model_i.got.delete();
         wait_lf;
      end
      host_link_model_i.got.delete();
      if (req) host_link_model_i.send("RD\r");
      wait_lf;
      e = '{8'h47, 8'h53, 8'h2C, st, 8'h2C,
            zero_tracking ? 8'h54 : 8'h41, 8'h2C, dc, 8'h2C,
            near_zero ? 8'h5A : 8'h4E, 8'h2C, reading_neg ? 8'h2D : 8'h30};
      n = host_link_model_i.got.size();
      check(8'(n), 8'd20);
      foreach (e[i]) check(host_link_model_i.got[i], e[i]);
      for (int k = 0; k < 5; k++)
         check(host_link_model_i.got[12+k],
               {4'h3, reading_bcd[19-4*k -: 4]});
      check(host_link_model_i.got[n-2], 8'h0D);
      check(host_link_model_i.got[n-1], 8'h0A);
   endtask : frame

   task automatic cmd(input string s, input logic [7:0] st);
      host_link_model_i.send(s);
      repeat (2) @(posedge ref_clk);
      #1;
      rchk(2'h0, st);
      reg_write(2'h0, 8'h0F);
   endtask : cmd

   initial begin
      #2_000_000;
      fails++;
      final_report;
   end

   initial begin
      {nrst, tx_mode, zero_permit, cal_lock} = 4'h0;
      {decision_trigger_permit, reg_wr, reg_rd} = 3'h0;
      {reg_addr, reg_wdata} = 10'h000;
      {clk_en, zero_tracking, near_zero} = 3'h4;
      hold_mode = hold_mode_off;
      reading_bcd = 20'h12345;
      stall = 4'h0;
      set_in(8'h40);
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check(rx_ready, 1'b1);
      rchk(2'h0, 8'h00);
      rchk(2'h2, 8'h00);
      reg_write(2'h3, 8'hFF);
      rchk(2'h3, 8'h00);
      // a frozen block must ignore a register write
      clk_en <= 1'b0;
      reg_write(2'h1, 8'h0F);
      clk_en <= 1'b1;
      rchk(2'h1, 8'h00);
      repeat (100) @(posedge ref_clk);
      check(8'(host_link_model_i.got.size()), 8'h00);
      frame(1'b1, 8'h53, 8'h46);
      rchk(2'h0, 8'h03);
      reg_write(2'h0, 8'h01);
      rchk(2'h0, 8'h02);
      stall <= 4'h3;
      tx_mode <= 1'b1;
      rchk(2'h2, 8'h01);
      for (int i = 0; i < 8; i++) begin
         set_in(tbl[i][23:16]);
         zero_tracking <= i[0];
         near_zero <= i[1];
         reading_bcd <= {5{i[3:0]}};
         frame(1'b0, tbl[i][15:8], tbl[i][7:0]);
      end
      tx_mode <= 1'b0;
      repeat (300) @(posedge ref_clk);
      reg_write(2'h0, 8'h0F);
      cmd("CE\r", 8'h04);
      check(hold_active, 1'b0);
      for (int k = 1; k < 4; k++) begin
         hold_mode <= hold_mode_t'(k);
         cmd("CE\r", 8'h02);
         check(hold_active, 1'b1);
         cmd("CF\r", 8'h02);
         check(hold_active, 1'b0);
      end
      cmd("CE\r", 8'h02);
      rchk(2'h2, 8'h02);
      set_in(8'h80);
      frame(1'b1, 8'h48, 8'h46);
      reg_write(2'h0, 8'h0F);
      cmd("CI\r", 8'h02);
      check(hold_active, 1'b0);
      zero_permit <= 1'b1;
      cmd("CG\r", 8'h04);
      check(8'(zset_n), 8'h00);
      cal_lock <= 1'b1;
      cmd("CG\r", 8'h02);
      check(8'(zset_n), 8'h01);
      zero_permit <= 1'b0;
      cmd("CG\r", 8'h04);
      cmd("CH\r", 8'h04);
      check(8'(zclr_n), 8'h00);
      zero_permit <= 1'b1;
      cmd("CH\r", 8'h02);
      check(8'(zclr_n), 8'h01);
      check(8'(zset_n), 8'h01);
      cmd("CJ\r", 8'h04);
      check(decision_trigger_input, 1'b0);
      decision_trigger_permit <= 1'b1;
      cmd("CJ\r", 8'h02);
      check(decision_trigger_input, 1'b1);
      cmd("CK\r", 8'h02);
      check(decision_trigger_input, 1'b0);
      cmd("CEX", 8'h08);
      reg_write(2'h1, 8'h02);
      rchk(2'h1, 8'h02);
      host_link_model_i.send("CK\r");
      repeat (4) @(posedge ref_clk);
      #1;
      check(irq, 1'b1);
      reg_write(2'h0, 8'h02);
      repeat (2) @(posedge ref_clk);
      #1;
      check(irq, 1'b0);
      decision_trigger_permit <= 1'b0;
      host_link_model_i.send("CJ\r");
      repeat (4) @(posedge ref_clk);
      #1;
      check(irq, 1'b0);
      rchk(2'h0, 8'h04);
      final_report;
   end
endmodule : indicator_serial_status_and_control_test
